// File: verilog/phc_holdover.sv
// holdover controller: registers, lock detector, pump tristate control
// assumes pin inputs asynchronous; phase event inputs are core-clock pulses
`timescale 1ns/10ps
module phc_holdover
(
  input  wire logic       core_clk_i,
  input  wire logic       reset_n_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic       align_pin_n_i,
  input  wire logic       lock_indicator_pin_i,
  input  wire logic       ref_edge_one_i,
  input  wire logic       ref_edge_two_i,
  input  wire logic       pfd_cycle_i,
  input  wire logic       in_lock_win_i,
  input  wire logic       over_unlock_i,
  output logic            pump_tristate_o,
  output logic            b_counter_reset_o,
  output logic            digital_lock_flag_o,
  output logic            lock_pin_current_o,
  output logic [1:0]      ref_buf_en_o,
  output logic            ref_auto_switch_o,
  output logic            ref_prefer_two_o,
  output logic            lock_window_low_o
);

  // ==========================================================
  // register file
  logic [7:0] lock_detect_config;
  logic [7:0] lock_pin_output_select;
  logic [7:0] reference_select_control;
  logic [7:0] holdover_control;
  phc_pkg::phc_state_type state;
  logic [7:0] next_rdata;
  logic       lock_sense;

  // software writes
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      lock_detect_config       <= phc_pkg::RST_LOCK_CFG;
      lock_pin_output_select   <= phc_pkg::RST_LOCK_PIN;
      reference_select_control <= phc_pkg::RST_REF_CTRL;
      holdover_control         <= phc_pkg::RST_HOLD_CTRL;
    end
    else if (wr_i)
    begin
      unique case (addr_i)
        phc_pkg::ADDR_LOCK_CFG:  lock_detect_config       <= wdata_i;
        phc_pkg::ADDR_LOCK_PIN:  lock_pin_output_select   <= wdata_i;
        phc_pkg::ADDR_REF_CTRL:  reference_select_control <= wdata_i;
        phc_pkg::ADDR_HOLD_CTRL: holdover_control         <= wdata_i;
        default: ;
      endcase
    end
  end

  // read mux, unmapped reads as zero
  always_comb
  begin
    next_rdata = 8'h00;
    unique case (addr_i)
      phc_pkg::ADDR_LOCK_CFG:  next_rdata = lock_detect_config;
      phc_pkg::ADDR_LOCK_PIN:  next_rdata = lock_pin_output_select;
      phc_pkg::ADDR_REF_CTRL:  next_rdata = reference_select_control;
      phc_pkg::ADDR_HOLD_CTRL: next_rdata = holdover_control;
      phc_pkg::ADDR_STATUS:
        next_rdata = {4'h0, lock_sense, digital_lock_flag_o,
                      b_counter_reset_o, pump_tristate_o};
      default: next_rdata = 8'h00;
    endcase
  end

  // read data one cycle after strobe
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
      rdata_o <= 8'h00;
    else if (rd_i)
      rdata_o <= next_rdata;
    else
      rdata_o <= 8'h00;
  end

  // ==========================================================
  // configuration outputs
  // reference control, lock window and lock pin select fields
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      ref_buf_en_o       <= 2'h0;
      ref_auto_switch_o  <= 1'b0;
      ref_prefer_two_o   <= 1'b0;
      lock_window_low_o  <= 1'b0;
      lock_pin_current_o <= 1'b0;
    end
    else
    begin
      ref_buf_en_o <= reference_select_control[phc_pkg::RS_BUF_LSB +: 2];
      ref_auto_switch_o <= reference_select_control[phc_pkg::RS_AUTO_BIT];
      ref_prefer_two_o  <= reference_select_control[phc_pkg::RS_PREF_BIT];
      lock_window_low_o <= lock_detect_config[phc_pkg::LD_WIN_BIT];
      lock_pin_current_o <=
        (lock_pin_output_select[5:0] == phc_pkg::LP_CURRENT);
    end
  end

  // ==========================================================
  // digital lock detector
  logic [7:0] good_cnt;
  logic [7:0] lock_target;

  always_comb
  begin
    unique case (lock_detect_config[phc_pkg::LD_CNT_LSB +: 2])
      2'h0: lock_target = phc_pkg::LD_CNT_00;
      2'h1: lock_target = phc_pkg::LD_CNT_01;
      2'h2: lock_target = phc_pkg::LD_CNT_10;
      2'h3: lock_target = phc_pkg::LD_CNT_11;
    endcase
  end

  // lock after n good, unlock after one bad
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i || lock_detect_config[phc_pkg::LD_DIS_BIT])
    begin
      good_cnt            <= 8'h00;
      digital_lock_flag_o <= 1'b0;
    end
    else if (pfd_cycle_i)
    begin
      if (over_unlock_i)
      begin
        good_cnt            <= 8'h00;
        digital_lock_flag_o <= 1'b0;
      end
      else if (!in_lock_win_i)
        good_cnt <= 8'h00;
      else if (good_cnt + 8'h01 >= lock_target)
      begin
        good_cnt            <= lock_target;
        digital_lock_flag_o <= 1'b1;
      end
      else
        good_cnt <= good_cnt + 8'h01;
    end
  end

  // ==========================================================
  // pin synchronisers and sensing
  logic [1:0] align_sync;
  logic [1:0] lock_sync;
  logic       align_prev;
  logic       align_fall;
  logic       ref_edge;

  // two-stage sync, edge from second stage
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      align_sync <= 2'h3;
      lock_sync  <= 2'h3; // pin idles high, locked
      align_prev <= 1'b1;
    end
    else
    begin
      align_sync <= {align_sync[0], align_pin_n_i};
      lock_sync  <= {lock_sync[0], lock_indicator_pin_i};
      align_prev <= align_sync[1];
    end
  end

  assign lock_sense = holdover_control[phc_pkg::HO_CMP_BIT] ?
                      lock_sync[1] : 1'b1;
  assign align_fall = align_prev & ~align_sync[1];
  // edge of the selected reference only
  assign ref_edge = ref_prefer_two_o ? ref_edge_two_i : ref_edge_one_i;

  // ==========================================================
  // holdover state machine
  logic ho_enable;
  logic ext_mode;

  assign ho_enable = holdover_control[phc_pkg::HO_EN0_BIT] &
                     holdover_control[phc_pkg::HO_EN2_BIT];
  assign ext_mode  = holdover_control[phc_pkg::HO_EXT_BIT];

  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i || !ho_enable)
      state <= phc_pkg::ST_RUN;
    else
    begin
      unique case (state)
        phc_pkg::ST_RUN:
          if (ext_mode ? align_fall : !lock_sense)
            state <= phc_pkg::ST_HOLD;
        phc_pkg::ST_HOLD:
          // exit on reference edge, pin high in manual
          if (ref_edge && (!ext_mode || align_sync[1]))
            state <= ext_mode ? phc_pkg::ST_RUN : phc_pkg::ST_REARM;
        phc_pkg::ST_REARM:
          // wait for pin to charge again
          if (ext_mode || lock_sense)
            state <= phc_pkg::ST_RUN;
        default: state <= phc_pkg::ST_RUN;
      endcase
    end
  end

  // b counter reset pulse on exit
  always_ff @(posedge core_clk_i)
  begin
    if (!reset_n_i)
    begin
      pump_tristate_o   <= 1'b0;
      b_counter_reset_o <= 1'b0;
    end
    else
    begin
      pump_tristate_o   <= (state == phc_pkg::ST_HOLD);
      b_counter_reset_o <= ho_enable && (state == phc_pkg::ST_HOLD) &&
                           ref_edge && (!ext_mode || align_sync[1]);
    end
  end

  // ==========================================================
  // assertions
  // no holdover when disabled
  hold_needs_en_a: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i) !ho_enable |=> ##1 !pump_tristate_o)
    else $error("pump tristated while holdover disabled");

  manual_entry_a: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    (ho_enable && ext_mode && state == phc_pkg::ST_RUN && align_fall
     && $stable(holdover_control)) |=> ##1 pump_tristate_o)
    else $error("manual holdover not entered");

  hold_stays_a: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    (state == phc_pkg::ST_HOLD && ho_enable && !ref_edge
     && $stable(holdover_control)) |=> state == phc_pkg::ST_HOLD)
    else $error("holdover left without reference edge");

  b_reset_exit_a: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    b_counter_reset_o |-> ##1 !pump_tristate_o)
    else $error("b counter reset without pump release");

  auto_entry_a: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    (ho_enable && !ext_mode && state == phc_pkg::ST_RUN && !lock_sense
     && $stable(holdover_control)) |=> ##1 pump_tristate_o)
    else $error("automatic holdover not entered");

  rearm_wait_a: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    (state == phc_pkg::ST_REARM && !lock_sense && !ext_mode
     && ho_enable && $stable(holdover_control))
    |=> state == phc_pkg::ST_REARM)
    else $error("rearmed before lock pin charged");

  unlock_one_a: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i) (pfd_cycle_i && over_unlock_i)
    |=> !digital_lock_flag_o)
    else $error("unlock not flagged");

  // code zero needs five good cycles
  lock_five_a: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    ($rose(digital_lock_flag_o) &&
     lock_detect_config[phc_pkg::LD_CNT_LSB +: 2] == 2'h0)
    |-> good_cnt == 8'h05)
    else $error("lock flagged at wrong count");

  pump_hold_a: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    (state == phc_pkg::ST_HOLD) |=> pump_tristate_o)
    else $error("pump not tristated in holdover");

  pump_run_a: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    (state != phc_pkg::ST_HOLD) |=> !pump_tristate_o)
    else $error("pump tristated outside holdover");

  pin_low_hold_a: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    (state == phc_pkg::ST_HOLD && ho_enable && ext_mode && !align_sync[1])
    |=> state == phc_pkg::ST_HOLD)
    else $error("manual holdover left while pin low");

  // b counter reset lasts one cycle
  b_reset_once_a: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    b_counter_reset_o |=> !b_counter_reset_o)
    else $error("b counter reset longer than one cycle");

  ref_exit_a: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    (state == phc_pkg::ST_HOLD && ho_enable && !ext_mode && ref_edge)
    |=> state == phc_pkg::ST_REARM)
    else $error("automatic holdover not left on reference edge");

  ext_ignores_lock_a: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    (state == phc_pkg::ST_RUN && ho_enable && ext_mode && !align_fall)
    |=> state == phc_pkg::ST_RUN)
    else $error("external holdover entered without pin edge");

  // comparator off never enters automatic hold
  cmp_off_run_a: assert property (@(posedge core_clk_i)
    disable iff (!reset_n_i)
    (state == phc_pkg::ST_RUN && ho_enable && !ext_mode
     && !holdover_control[phc_pkg::HO_CMP_BIT])
    |=> state == phc_pkg::ST_RUN)
    else $error("automatic holdover entered with comparator off");

  reset_clears_a: assert property (@(posedge core_clk_i)
    !reset_n_i |=> state == phc_pkg::ST_RUN && !pump_tristate_o)
    else $error("holdover not cleared by reset");

endmodule : phc_holdover

// File: verilog/phc_pkg.sv
// constants and register map of the pll holdover controller
// assumes one 125 MHz core clock and a plain strobe register port
//
// Contract
// - holdover tristates the charge pump instead of pumping up or down
// - manual and automatic holdover act only with both enable bits set
// - manual mode enters holdover at once on alignment pin falling edge
// - manual exit only on next reference phase detector rising edge; the code also waits for the alignment pin to be high again
// - leaving holdover resets the b counter, never the prescaler
// - automatic mode enters holdover whenever lock is lost
// - automatic entry condition is the sensed lock indicator pin level
// - comparator disabled means the lock pin is treated as high
// - automatic holdover persists while no reference edge arrives
// - no re-entry until lock regained and lock pin charged again
// - holdover follows selected reference; switchover loss lasts one edge
// - lock counter field sets consecutive in-window cycles; 00b is five
// - lock pin select code 000100b picks current source lock mode
// - external control bit 1 selects alignment pin, 0 automatic
// - lock window bit 0 selects the high range window
// - reference control bit4 auto switch, bit3 prefer, bits 2:1 buffers
// - lock after n good cycles, unlock after one cycle over threshold
package phc_pkg;
  // register offsets
  localparam logic [7:0] ADDR_LOCK_CFG   = 8'h18;
  localparam logic [7:0] ADDR_LOCK_PIN   = 8'h1a;
  localparam logic [7:0] ADDR_REF_CTRL   = 8'h1c;
  localparam logic [7:0] ADDR_HOLD_CTRL  = 8'h1d;
  localparam logic [7:0] ADDR_STATUS     = 8'h1f;
  // reset values
  localparam logic [7:0] RST_LOCK_CFG    = 8'h08;
  localparam logic [7:0] RST_LOCK_PIN    = 8'h00;
  localparam logic [7:0] RST_REF_CTRL    = 8'h00;
  localparam logic [7:0] RST_HOLD_CTRL   = 8'h00;
  // lock_detect_config fields
  localparam int LD_CNT_LSB   = 5;
  localparam int LD_WIN_BIT   = 4;
  localparam int LD_DIS_BIT   = 3;
  // holdover_control fields
  localparam int HO_EN0_BIT   = 0;
  localparam int HO_EXT_BIT   = 1;
  localparam int HO_EN2_BIT   = 2;
  localparam int HO_CMP_BIT   = 3;
  // reference_select_control fields
  localparam int RS_AUTO_BIT  = 4;
  localparam int RS_PREF_BIT  = 3;
  localparam int RS_BUF_LSB   = 1;
  // lock pin select codes
  localparam logic [5:0] LP_DIGITAL  = 6'h01;
  localparam logic [5:0] LP_CURRENT  = 6'h04;
  // lock counter codes to cycle counts
  localparam logic [7:0] LD_CNT_00   = 8'h05;
  localparam logic [7:0] LD_CNT_01   = 8'h10;
  localparam logic [7:0] LD_CNT_10   = 8'h40;
  localparam logic [7:0] LD_CNT_11   = 8'hff;
  // hold state
  typedef enum logic [1:0] {ST_RUN, ST_HOLD, ST_REARM} phc_state_type;
endpackage : phc_pkg

// File: verif/phc_far_side.sv
// far side model: reference edge sources and phase detector events
// assumes the bench starts and stops the reference and picks bad cycles
`timescale 1ns/10ps
module phc_far_side
(
  input  wire logic core_clk_i,
  input  wire logic run_i,
  input  wire logic bad_i,
  input  wire logic lose_one_i,
  output logic      ref_edge_one_o,
  output logic      ref_edge_two_o,
  output logic      pfd_cycle_o,
  output logic      in_lock_win_o,
  output logic      over_unlock_o
);
  logic [2:0] div = 3'h0;

  // one reference edge and one pfd cycle every eight clocks while running
  // a stopped reference gives no edges at all, as a lost clock would
  // a lost reference one keeps its own edge input quiet
  always @(posedge core_clk_i)
  begin
    div            <= run_i ? div + 3'h1 : 3'h0;
    ref_edge_one_o <= run_i && div == 3'h7 && !lose_one_i;
    ref_edge_two_o <= run_i && div == 3'h7;
    pfd_cycle_o    <= run_i && div == 3'h7;
    in_lock_win_o  <= run_i && div == 3'h7 && !bad_i;
    over_unlock_o  <= run_i && div == 3'h7 && bad_i;
  end
endmodule : phc_far_side

// File: verif/phc_holdover_tb.sv
// self-checking bench of the holdover controller
// assumes the far side model drives the reference and pfd event inputs
`timescale 1ns/10ps
module phc_holdover_tb;
  logic       core_clk_i = 1'b0;
  logic       reset_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic       wr_i = 1'b0;
  logic       rd_i = 1'b0;
  logic       align_pin_n_i = 1'b1;
  logic       lock_pin = 1'b1;
  logic       run = 1'b0;
  logic       bad = 1'b0;
  logic       lose_one = 1'b0;
  logic [7:0] rdata_o;
  logic       pump_tristate_o, b_counter_reset_o, digital_lock_flag_o;
  logic       lock_pin_current_o, ref_auto_switch_o, ref_prefer_two_o;
  logic       lock_window_low_o, ref_one, ref_two, pfd, in_win, over;
  logic [1:0] ref_buf_en_o;
  int         error_cnt = 0;
  int         cmp_count = 0;

  always #4 core_clk_i = ~core_clk_i;

  phc_far_side phc_far_side_inst (.core_clk_i(core_clk_i), .run_i(run),
    .bad_i(bad), .lose_one_i(lose_one), .ref_edge_one_o(ref_one),
    .ref_edge_two_o(ref_two), .pfd_cycle_o(pfd), .in_lock_win_o(in_win),
    .over_unlock_o(over));

  phc_holdover phc_holdover_inst (.core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .align_pin_n_i(align_pin_n_i), .lock_indicator_pin_i(lock_pin),
    .ref_edge_one_i(ref_one), .ref_edge_two_i(ref_two),
    .pfd_cycle_i(pfd), .in_lock_win_i(in_win), .over_unlock_i(over),
    .pump_tristate_o(pump_tristate_o),
    .b_counter_reset_o(b_counter_reset_o),
    .digital_lock_flag_o(digital_lock_flag_o),
    .lock_pin_current_o(lock_pin_current_o), .ref_buf_en_o(ref_buf_en_o),
    .ref_auto_switch_o(ref_auto_switch_o),
    .ref_prefer_two_o(ref_prefer_two_o),
    .lock_window_low_o(lock_window_low_o));

  // ====================================================
  // shared tasks
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : cyc

  function automatic logic obs(input int sel);
    case (sel)
      0: return pump_tristate_o;
      1: return b_counter_reset_o;
      2: return digital_lock_flag_o;
      default: return pfd;
    endcase
  endfunction : obs

  // bounded wait for one output to reach a level
  task automatic wait_for(input int sel, input logic exp, input int lim);
    for (int n = 0; n < lim && obs(sel) !== exp; n++)
      cyc(1);
    chk(8'(obs(sel)), 8'(exp));
    if (obs(sel) !== exp)
      stop_test();
  endtask : wait_for

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge core_clk_i);
    wr_i    <= 1'b0;
    #1;
  endtask : wr_reg

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge core_clk_i);
    rd_i   <= 1'b0;
    #1;
    chk(rdata_o, exp);
  endtask : rd_chk

  // ====================================================
  // scenarios
  task automatic t_regs;
    rd_chk(phc_pkg::ADDR_LOCK_CFG, phc_pkg::RST_LOCK_CFG);
    rd_chk(phc_pkg::ADDR_HOLD_CTRL, phc_pkg::RST_HOLD_CTRL);
    wr_reg(8'h05, 8'hff);
    rd_chk(8'h05, 8'h00);
    wr_reg(phc_pkg::ADDR_LOCK_PIN, 8'h04);
    cyc(2);
    chk(8'(lock_pin_current_o), 8'h01);
    wr_reg(phc_pkg::ADDR_REF_CTRL, 8'h16);
    rd_chk(phc_pkg::ADDR_REF_CTRL, 8'h16);
    chk(8'({ref_auto_switch_o, ref_prefer_two_o, ref_buf_en_o}),
        8'h0b);
    wr_reg(phc_pkg::ADDR_LOCK_CFG, 8'h10);
    cyc(2);
    chk(8'(lock_window_low_o), 8'h01);
    $display("test registers done");
  endtask : t_regs

  task automatic t_manual;
    wr_reg(phc_pkg::ADDR_HOLD_CTRL, 8'h02);
    align_pin_n_i <= 1'b0;
    cyc(10);
    chk(8'(pump_tristate_o), 8'h00);
    align_pin_n_i <= 1'b1;
    wr_reg(phc_pkg::ADDR_HOLD_CTRL, 8'h07);
    cyc(4);
    align_pin_n_i <= 1'b0;
    wait_for(0, 1'b1, 6);
    align_pin_n_i <= 1'b1;
    cyc(20);
    chk(8'(pump_tristate_o), 8'h01);
    rd_chk(phc_pkg::ADDR_STATUS, 8'h09);
    run <= 1'b1;
    wait_for(1, 1'b1, 20);
    chk(8'(pump_tristate_o), 8'h01);
    cyc(1);
    chk({b_counter_reset_o, pump_tristate_o}, 8'h00);
    run <= 1'b0;
    $display("test manual done");
  endtask : t_manual

  task automatic t_auto;
    // detector on and current source lock mode
    wr_reg(phc_pkg::ADDR_LOCK_CFG, 8'h00);
    wr_reg(phc_pkg::ADDR_LOCK_PIN, 8'h04);
    wr_reg(phc_pkg::ADDR_HOLD_CTRL, 8'h05);
    lock_pin <= 1'b0;
    cyc(10);
    chk(8'(pump_tristate_o), 8'h00);
    wr_reg(phc_pkg::ADDR_HOLD_CTRL, 8'h0d);
    wait_for(0, 1'b1, 6);
    cyc(20);
    chk(8'(pump_tristate_o), 8'h01);
    run <= 1'b1;
    wait_for(1, 1'b1, 20);
    wait_for(0, 1'b0, 2);
    cyc(20);
    chk(8'(pump_tristate_o), 8'h00);
    lock_pin <= 1'b1;
    cyc(6);
    lock_pin <= 1'b0;
    wait_for(0, 1'b1, 6);
    wr_reg(phc_pkg::ADDR_HOLD_CTRL, 8'h00);
    wait_for(0, 1'b0, 4);
    lock_pin <= 1'b1;
    $display("test automatic done");
  endtask : t_auto

  task automatic t_lockdet;
    bad <= 1'b1;
    run <= 1'b1;
    wait_for(2, 1'b0, 20);
    wait_for(3, 1'b1, 10);
    bad <= 1'b0;
    repeat (4)
    begin
      cyc(1);
      wait_for(3, 1'b1, 10);
    end
    cyc(3);
    chk(8'(digital_lock_flag_o), 8'h00);
    wait_for(3, 1'b1, 10);
    wait_for(2, 1'b1, 4);
    run <= 1'b0;
    $display("test lock detector done");
  endtask : t_lockdet

  // reference one lost, reference two selected, then a reset during holdover
  task automatic t_switch;
    lose_one <= 1'b1;
    run      <= 1'b1;
    wr_reg(phc_pkg::ADDR_HOLD_CTRL, 8'h07);
    cyc(4);
    align_pin_n_i <= 1'b0;
    wait_for(0, 1'b1, 6);
    align_pin_n_i <= 1'b1;
    cyc(24);
    chk(8'(pump_tristate_o), 8'h01);
    wr_reg(phc_pkg::ADDR_REF_CTRL, 8'h1e);
    wait_for(1, 1'b1, 20);
    wait_for(0, 1'b0, 2);
    run <= 1'b0;
    // later pin event, enters holdover again
    align_pin_n_i <= 1'b0;
    wait_for(0, 1'b1, 6);
    reset_n_i     <= 1'b0;
    align_pin_n_i <= 1'b1;
    cyc(2);
    reset_n_i <= 1'b1;
    chk(8'(pump_tristate_o), 8'h00);
    cyc(2);
    chk(8'(pump_tristate_o), 8'h00);
    rd_chk(phc_pkg::ADDR_HOLD_CTRL, phc_pkg::RST_HOLD_CTRL);
    lose_one <= 1'b0;
    $display("test switchover done");
  endtask : t_switch

  // ====================================================
  // main sequence
  initial
  begin
    repeat (16) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    cyc(1);
    chk(8'(pump_tristate_o), 8'h00);
    t_regs();
    t_manual();
    t_auto();
    t_lockdet();
    t_switch();
    stop_test();
  end
endmodule : phc_holdover_tb
